// ==== logic/fpv_map.svh ====
// Register map, field layout, reset values and timing figures of the fan PWM block.
// Assumes it is included by bare name wherever these names are used.
`ifndef FPV_MAP_SVH
`define FPV_MAP_SVH

`define FPV_ADDR_DUTY 8'h4C
`define FPV_ADDR_DIV 8'h4D
`define FPV_ADDR_SHIFT 8'h4E

`define FPV_DUTY_RST 8'h00
`define FPV_DIV_RST 5'h17
`define FPV_SHIFT_RST 6'h00

`define FPV_EXT_HI 7
`define FPV_EXT_LO 6
`define FPV_BASE_HI 5
`define FPV_DIV_HI 4
`define FPV_SHIFT_HI 5

`define FPV_HI_SHIFT 8
`define FPV_LO_SHIFT 6

`define FPV_REF_HZ 20000000
`define FPV_MCLK_FAST_HZ 360000
`define FPV_MCLK_SLOW_HZ 1400
`define FPV_CYC(hz) ((`FPV_REF_HZ + (hz) / 2) / (hz))

`endif

// ==== logic/fpv_pkg.sv ====
// Types of the fan PWM value and frequency block.
// Assumes fpv_map.svh for widths it shares with the map.
package fpv_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } fpv_reg_req_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic rvalid;
    } fpv_reg_rsp_t;

    typedef struct packed {
        logic direct_prog;
        logic mclk_slow;
        logic high_res;
        logic spinup_active;
        logic [7:0] spinup_duty;
        logic [7:0] lut_duty;
    } fpv_ctl_t;

    typedef struct packed {
        logic [13:0] pre_cnt;
        logic [5:0] pos;
        logic [5:0] period;
        logic [7:0] duty_l;
        logic [7:0] duty_sw;
        logic [4:0] divisor;
        logic [5:0] temp_shift;
        logic [7:0] rdata;
        logic rvalid;
        logic pwm_on;
    } fpv_state_t;
endpackage : fpv_pkg

// ==== logic/fpv_top.sv ====
// Fan PWM value register, output frequency divider and lookup offset register.
// Assumes a register port fed by the serial management bus logic, and
// control levels from the fan configuration and spin-up logic.
//
// Contract
// [R01] Program bit clear: duty register read-only, returns lookup-table duty.
// [R02] Program bit set: duty register writable, output driven from written value.
// [R03] In direct mode written duty replaces lookup result as PWM source.
// [R04] During spin-up, duty register reads zero.
// [R05] Duty register is 8 bits: 2 extension bits over 6 base bits.
// [R06] Output frequency is master clock over twice the 5-bit divisor.
// [R07] Master clock is 360 kHz or 1.4 kHz by select bit.
// [R08] Divisor zero behaves as divisor one.
// [R09] Unused upper bits of divisor and offset registers ignore writes, read zero.
// [R10] Output high for portion of period proportional to duty.
`timescale 1ns/100ps
`include "fpv_map.svh"

module fpv_top #(
    parameter int unsigned P_SLOW_CNT = `FPV_CYC(`FPV_MCLK_SLOW_HZ)
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Register port
    input wire fpv_pkg::fpv_reg_req_t i_reg,
    output fpv_pkg::fpv_reg_rsp_t o_reg,
    // Fan control levels
    input wire fpv_pkg::fpv_ctl_t i_ctl,
    output logic [5:0] o_table_temp_shift,
    // Open-drain fan pin
    input wire logic i_fan_pwm,
    output logic o_fan_pwm,
    output logic o_fan_pwm_oe_n,
    output logic o_fan_pin_level
);
    import fpv_pkg::*;

    localparam int unsigned FAST_CNT = `FPV_CYC(`FPV_MCLK_FAST_HZ);

    fpv_state_t st;
    fpv_state_t next_st;

    logic [13:0] tick_limit;
    logic tick;
    logic [4:0] eff_n;
    logic [5:0] period_now;
    logic [7:0] cur_duty;
    logic [7:0] duty_read;
    logic [13:0] pos_scaled;
    logic [13:0] duty_scaled;
    logic pin_level;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction : hit

    always_comb begin
        tick_limit = i_ctl.mclk_slow ? 14'(P_SLOW_CNT) : 14'(FAST_CNT); // R07
        // Compare with >= so a switch to a shorter count never wraps the prescaler
        tick = (st.pre_cnt >= tick_limit - 14'h0001); // R07
        // Zero would give a zero-length period and stall the counter
        eff_n = (st.divisor == 5'h00) ? 5'h01 : st.divisor; // R08
        period_now = {eff_n, 1'b0}; // R06
        // Spin-up owns the pin; otherwise the program bit picks the source
        if (i_ctl.spinup_active) begin
            cur_duty = i_ctl.spinup_duty;
        end else if (i_ctl.direct_prog) begin
            cur_duty = st.duty_sw; // R03
        end else begin
            cur_duty = i_ctl.lut_duty; // R01
        end
        duty_read = i_ctl.spinup_active ? 8'h00 : cur_duty; // R04
        // Compare position against duty on a common 14-bit scale
        if (i_ctl.high_res) begin
            pos_scaled = {st.pos, 8'h00};
            duty_scaled = 14'(st.duty_l) * 14'(st.period); // R05
        end else begin
            pos_scaled = {2'h0, st.pos, 6'h00};
            duty_scaled = 14'(st.duty_l[`FPV_BASE_HI:0]) * 14'(st.period); // R05
        end
    end

    always_comb begin
        next_st = st;
        next_st.rvalid = 1'b0;
        next_st.pre_cnt = tick ? 14'h0000 : st.pre_cnt + 14'h0001;
        if (tick) begin
            // Duty and period only change on a period boundary, no runt pulses
            if (st.pos >= st.period - 6'h01) begin
                next_st.pos = 6'h00; // R06
                next_st.period = period_now; // R06
                next_st.duty_l = cur_duty; // R02
            end else begin
                next_st.pos = st.pos + 6'h01; // R10
            end
        end
        next_st.pwm_on = (pos_scaled < duty_scaled); // R10
        if (i_reg.wr) begin
            if (hit(i_reg.addr, `FPV_ADDR_DUTY) && i_ctl.direct_prog) begin
                next_st.duty_sw = i_reg.wdata; // R02
            end
            if (hit(i_reg.addr, `FPV_ADDR_DIV)) begin
                next_st.divisor = i_reg.wdata[`FPV_DIV_HI:0]; // R09
            end
            if (hit(i_reg.addr, `FPV_ADDR_SHIFT)) begin
                next_st.temp_shift = i_reg.wdata[`FPV_SHIFT_HI:0]; // R09
            end
        end
        if (i_reg.rd) begin
            next_st.rvalid = 1'b1;
            if (hit(i_reg.addr, `FPV_ADDR_DUTY)) begin
                next_st.rdata = duty_read; // R04
            end else if (hit(i_reg.addr, `FPV_ADDR_DIV)) begin
                next_st.rdata = {3'h0, st.divisor}; // R09
            end else if (hit(i_reg.addr, `FPV_ADDR_SHIFT)) begin
                next_st.rdata = {2'h0, st.temp_shift}; // R09
            end else begin
                next_st.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st.pre_cnt <= 14'h0000;
            st.pos <= 6'h00;
            st.period <= {`FPV_DIV_RST, 1'b0};
            st.duty_l <= `FPV_DUTY_RST;
            st.duty_sw <= `FPV_DUTY_RST;
            st.divisor <= `FPV_DIV_RST;
            st.temp_shift <= `FPV_SHIFT_RST;
            st.rdata <= 8'h00;
            st.rvalid <= 1'b0;
            st.pwm_on <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_level <= 1'b0;
        end else begin
            pin_level <= i_fan_pwm;
        end
    end

    // Open drain: release for the on phase, pull low otherwise
    assign o_fan_pwm = 1'b0;
    assign o_fan_pwm_oe_n = st.pwm_on;
    assign o_fan_pin_level = pin_level;
    assign o_reg.rdata = st.rdata;
    assign o_reg.rvalid = st.rvalid;
    assign o_table_temp_shift = st.temp_shift;

    duty_locked_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R01
        i_reg.wr && hit(i_reg.addr, `FPV_ADDR_DUTY) && !i_ctl.direct_prog |=> $stable(st.duty_sw))
        else $error("duty register changed while read-only");

    lut_readback_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R01
        i_reg.rd && hit(i_reg.addr, `FPV_ADDR_DUTY) && !i_ctl.direct_prog && !i_ctl.spinup_active
        |=> o_reg.rdata == $past(i_ctl.lut_duty))
        else $error("duty read does not show table value");

    duty_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R02
        i_reg.wr && hit(i_reg.addr, `FPV_ADDR_DUTY) && i_ctl.direct_prog
        |=> st.duty_sw == $past(i_reg.wdata))
        else $error("direct duty write lost");

    direct_src_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R03
        tick && st.pos >= st.period - 6'h01 && i_ctl.direct_prog && !i_ctl.spinup_active
        |=> st.duty_l == $past(st.duty_sw))
        else $error("direct duty not used as source");

    spin_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R04
        i_reg.rd && hit(i_reg.addr, `FPV_ADDR_DUTY) && i_ctl.spinup_active
        |=> o_reg.rvalid && o_reg.rdata == 8'h00)
        else $error("duty read nonzero during spin-up");

    period_wrap_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R06
        tick && st.pos >= st.period - 6'h01 |=> st.pos == 6'h00 && st.period == {$past(eff_n), 1'b0})
        else $error("period wrap wrong");

    tick_gap_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R07
        tick && !i_ctl.mclk_slow ##1 !i_ctl.mclk_slow [*8] |-> !tick)
        else $error("master tick too frequent");

    div_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R08
        st.divisor == 5'h00 |-> period_now == 6'h02)
        else $error("zero divisor not mapped to one");

    rsv_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R09
        i_reg.rd && (hit(i_reg.addr, `FPV_ADDR_DIV) || hit(i_reg.addr, `FPV_ADDR_SHIFT))
        |=> o_reg.rdata[7:6] == 2'h0)
        else $error("reserved bits read nonzero");

    zero_duty_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R10
        st.duty_l == 8'h00 && $stable(st.duty_l) |=> !st.pwm_on)
        else $error("output on with zero duty");

    // Register port checks
    div_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R09
        i_reg.wr && hit(i_reg.addr, `FPV_ADDR_DIV)
        |=> st.divisor == $past(i_reg.wdata[`FPV_DIV_HI:0]))
        else $error("divisor write lost");

    div_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R09
        !(i_reg.wr && hit(i_reg.addr, `FPV_ADDR_DIV))
        |=> $stable(st.divisor))
        else $error("divisor changed without a write");

    shift_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R09
        i_reg.wr && hit(i_reg.addr, `FPV_ADDR_SHIFT)
        |=> st.temp_shift == $past(i_reg.wdata[`FPV_SHIFT_HI:0]))
        else $error("offset write lost");

    div_rsv_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R09
        i_reg.rd && hit(i_reg.addr, `FPV_ADDR_DIV)
        |=> o_reg.rdata[7:5] == 3'h0)
        else $error("divisor reserved bits read nonzero");

    unmapped_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R09
        i_reg.rd && !hit(i_reg.addr, `FPV_ADDR_DUTY) && !hit(i_reg.addr, `FPV_ADDR_DIV)
        && !hit(i_reg.addr, `FPV_ADDR_SHIFT) |=> o_reg.rdata == 8'h00)
        else $error("unmapped read nonzero");

    read_answer_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R01
        i_reg.rd
        |=> o_reg.rvalid)
        else $error("read not answered");

    read_quiet_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R01
        !i_reg.rd
        |=> !o_reg.rvalid)
        else $error("read valid without a read");

    rdata_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R01
        !i_reg.rd
        |=> $stable(o_reg.rdata))
        else $error("read data moved without a read");

    direct_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R02
        i_reg.rd && hit(i_reg.addr, `FPV_ADDR_DUTY) && i_ctl.direct_prog && !i_ctl.spinup_active
        |=> o_reg.rdata == $past(st.duty_sw))
        else $error("duty read does not show written value");

    duty_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R02
        !(i_reg.wr && hit(i_reg.addr, `FPV_ADDR_DUTY) && i_ctl.direct_prog)
        |=> $stable(st.duty_sw))
        else $error("written duty changed without a write");

    // PWM timing checks
    tick_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R07
        tick
        |=> st.pre_cnt == 14'h0000)
        else $error("prescaler not cleared on tick");

    tick_count_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R07
        !tick
        |=> st.pre_cnt == $past(st.pre_cnt) + 14'h0001)
        else $error("prescaler skipped a count");

    pos_step_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R10
        tick && st.pos < st.period - 6'h01
        |=> st.pos == $past(st.pos) + 6'h01)
        else $error("position did not advance on tick");

    pos_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R06
        !tick
        |=> $stable(st.pos) && $stable(st.period) && $stable(st.duty_l))
        else $error("period state moved between ticks");

    pos_bound_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R06
        st.pos < st.period)
        else $error("position beyond period");

    period_even_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R06
        st.period[0] == 1'b0 && st.period != 6'h00)
        else $error("period not twice a nonzero divisor");

    zero_wrap_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R08
        tick && st.pos >= st.period - 6'h01 && st.divisor == 5'h00
        |=> st.period == 6'h02)
        else $error("zero divisor period not two ticks");

    lut_src_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R01
        tick && st.pos >= st.period - 6'h01 && !i_ctl.direct_prog && !i_ctl.spinup_active
        |=> st.duty_l == $past(i_ctl.lut_duty))
        else $error("table duty not used as source");

    spin_src_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R03
        tick && st.pos >= st.period - 6'h01 && i_ctl.spinup_active
        |=> st.duty_l == $past(i_ctl.spinup_duty))
        else $error("spin-up duty not used as source");

    // Nonzero duty (base bits only in low-res mode) must give an on phase at the start of every period
    start_on_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R10
        st.pos == 6'h00 && (i_ctl.high_res ? st.duty_l != 8'h00 : st.duty_l[`FPV_BASE_HI:0] != 6'h00)
        |=> st.pwm_on)
        else $error("output off at period start");

endmodule : fpv_top

// ==== tb/fpv_fan_model.sv ====
// Fan input on the open-drain PWM pin, with the pin's pull-up.
// Assumes the device pulls the pin low only while oe_n is low.
`timescale 1ns/100ps
module fpv_fan_model (
    // Pin side
    input wire logic i_oe_n,
    output logic o_pin
);
    // Released pin floats up, never keeps a stale low
    assign o_pin = (i_oe_n === 1'b0) ? 1'b0 : 1'b1;
endmodule : fpv_fan_model

// ==== tb/fpv_tb_top.sv ====
// Bench of the fan PWM block: register port and pin timing.
// Assumes the fan model on the pin and a prescale of 4 for the slow clock.
`timescale 1ns/100ps
`include "fpv_map.svh"
module fpv_tb_top;
    import fpv_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    fpv_reg_req_t req = '0;
    fpv_reg_rsp_t rsp;
    fpv_ctl_t ctl = '0;
    logic [5:0] shift;
    logic pin;
    logic oe_n;
    logic lvl;
    logic [7:0] d;
    int n_fail = 0;
    int cmp_count = 0;
    int seed = 95;
    int cyc = 0;
    fpv_top #(.P_SLOW_CNT(4)) uut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_reg(req), .o_reg(rsp),
        .i_ctl(ctl), .o_table_temp_shift(shift), .i_fan_pwm(pin), .o_fan_pwm(),
        .o_fan_pwm_oe_n(oe_n), .o_fan_pin_level(lvl));
    fpv_fan_model fan (.i_oe_n(oe_n), .o_pin(pin));
    initial forever #25 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc > 30000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge i_ref_clk) #1;
        req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: dat};
        @(posedge i_ref_clk) #1;
        req.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_ref_clk) #1;
        req.addr = a;
        req.rd = 1'b1;
        @(posedge i_ref_clk) #1;
        req.rd = 1'b0;
        chk("rvalid", rsp.rvalid, 1'b1);
        chk("rdata", rsp.rdata, exp);
    endtask : rd
    // Divisor zero counts as one
    function automatic int exp_period(input int t, input logic [4:0] n);
        return 2 * t * ((n == 5'h00) ? 1 : int'(n));
    endfunction : exp_period
    task automatic rise();
        logic p;
        do begin
            p = lvl;
            @(posedge i_ref_clk) #1;
        end while (!(lvl === 1'b1 && p === 1'b0));
    endtask : rise
    // Two rises first, since a new divisor and duty land only at a period boundary
    task automatic measure(input int t, input logic [4:0] n);
        int per;
        int hi;
        logic p;
        rise();
        rise();
        per = 0;
        hi = 0;
        do begin
            hi += int'(lvl);
            per++;
            p = lvl;
            @(posedge i_ref_clk) #1;
        end while (!(lvl === 1'b1 && p === 1'b0));
        chk("period", 16'(per), 16'(exp_period(t, n)));
        chk("high", 16'(hi), 16'(exp_period(t, n) / 2));
        $display("test pwm divisor %0d done", n);
    endtask : measure
    initial begin
        ctl.lut_duty = 8'($random(seed));
        repeat (2) @(posedge i_ref_clk);
        #1 i_rst_n = 1'b1;
        rd(`FPV_ADDR_DIV, 8'h17);
        rd(`FPV_ADDR_DUTY, ctl.lut_duty);
        wr(`FPV_ADDR_DUTY, 8'h80);
        rd(`FPV_ADDR_DUTY, ctl.lut_duty);
        wr(`FPV_ADDR_DIV, 8'hFF);
        wr(`FPV_ADDR_SHIFT, 8'hFF);
        rd(`FPV_ADDR_DIV, 8'h1F);
        rd(`FPV_ADDR_SHIFT, 8'h3F);
        chk("shift", shift, 6'h3F);
        rd(8'h4F, 8'h00);
        $display("test registers done");
        ctl.direct_prog = 1'b1;
        d = 8'($random(seed));
        wr(`FPV_ADDR_DUTY, d);
        rd(`FPV_ADDR_DUTY, d);
        ctl.spinup_active = 1'b1;
        rd(`FPV_ADDR_DUTY, 8'h00);
        ctl.spinup_active = 1'b0;
        $display("test direct duty done");
        ctl.high_res = 1'b1;
        wr(`FPV_ADDR_DUTY, 8'h80);
        wr(`FPV_ADDR_DIV, 8'h00);
        measure(56, 5'h00);
        wr(`FPV_ADDR_DIV, 8'h05);
        measure(56, 5'h05);
        ctl.mclk_slow = 1'b1;
        wr(`FPV_ADDR_DIV, 8'h03);
        measure(4, 5'h03);
        ctl.mclk_slow = 1'b0;
        ctl.high_res = 1'b0;
        wr(`FPV_ADDR_DUTY, 8'h20);
        wr(`FPV_ADDR_DIV, 8'h02);
        measure(56, 5'h02);
        tally_and_finish();
    end
endmodule : fpv_tb_top
